//--- common/amp_misc_pkg.sv
/*
  shared constants and carrier types for the amplifier misc control bank:
  register offsets, reset values, field positions, pin function codes,
  silence timeout lengths in samples.
  assumes a single 200 MHz system clock and a 96 kHz reference sample rate.
*/
package amp_misc_pkg;

  // register offsets
  localparam logic [7:0] OFS_SILENCE_TIMEOUT = 8'h51;
  localparam logic [7:0] OFS_LOOP_BW = 8'h53;
  localparam logic [7:0] OFS_ATTENUATION = 8'h54;
  localparam logic [7:0] OFS_COEF_MARKER = 8'h5c;
  localparam logic [7:0] OFS_MODULATOR = 8'h5d;
  localparam logic [7:0] OFS_PIN_DIRECTION = 8'h60;
  localparam logic [7:0] OFS_PIN_FUNCTION = 8'h61;
  localparam logic [7:0] OFS_DSP_BYPASS = 8'h66;
  localparam logic [7:0] OFS_CHIP_ID = 8'h67;

  // reset values
  localparam logic [7:0] RST_SILENCE_TIMEOUT = 8'h00;
  localparam logic [7:0] RST_LOOP_BW = 8'h00;
  localparam logic [7:0] RST_ATTENUATION = 8'h00;
  localparam logic [7:0] RST_COEF_MARKER = 8'h00;
  localparam logic [7:0] RST_MODULATOR = 8'hf8;
  localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
  localparam logic [7:0] RST_PIN_FUNCTION = 8'h00;
  localparam logic [7:0] RST_DSP_BYPASS = 8'h00;

  // field positions
  localparam int LEFT_TIMEOUT_LSB = 4;
  localparam int RIGHT_TIMEOUT_LSB = 0;
  localparam int LOOP_BW_LSB = 5;
  localparam int ATTEN_LSB = 0;
  localparam int COEF_FIRST_BIT = 0;
  localparam int DAC_RATE_BIT = 7;
  localparam int DITHER_EN_LSB = 5;
  localparam int DITHER_LEVEL_LSB = 2;
  localparam int MISMATCH_LSB = 0;
  localparam int PIN_OE_BIT = 0;
  localparam int PIN_FUNC_LSB = 0;
  localparam int OWN_COEF_BIT = 3;
  localparam int FIR_BYPASS_BIT = 2;
  localparam int DRC_BYPASS_BIT = 1;
  localparam int EQ_BYPASS_BIT = 0;

  // dither level exponents
  localparam logic [4:0] DITHER_EXP_HIGH_BASE = 5'h07;
  localparam logic [4:0] DITHER_EXP_LOW_BASE = 5'h0d;

  // multi-purpose pin functions
  typedef enum logic [4:0] {
    PIN_OFF = 5'h00,
    PIN_BOTH_MUTE = 5'h03,
    PIN_LEFT_MUTE = 5'h04,
    PIN_RIGHT_MUTE = 5'h05,
    PIN_CLK_INVALID = 5'h06,
    PIN_FAULT = 5'h0b
  } pin_func_t;

  // silence timeouts in microseconds at the reference rate
  localparam longint unsigned REF_RATE_HZ = 96000;
  localparam longint unsigned TIMEOUT_US [8] = '{
    11500, 53000, 106500, 266500, 535000, 1065000, 2665000, 5330000};
  localparam int COUNT_W = 20;

  // length of the zero run for a timeout code, in samples
  function automatic logic [COUNT_W-1:0] timeout_samples(input logic [2:0] code);
    longint unsigned n;
    n = TIMEOUT_US[code] * REF_RATE_HZ / 64'd1000000;
    return n[COUNT_W-1:0];
  endfunction

  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // per-channel silence timer state
  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic silent;
  } timer_state_t;

  // whole bank state
  typedef struct packed {
    logic [7:0] silence_timeout;
    logic [7:0] loop_bandwidth_ctrl;
    logic [7:0] output_attenuation;
    logic [7:0] coef_write_marker;
    logic [7:0] modulator_config;
    logic [7:0] multi_pin_direction;
    logic [7:0] multi_pin_function;
    logic [7:0] dsp_bypass_options;
    logic [7:0] rdata;
    logic rvalid;
    logic coef_start;
    logic [2:0] pin_sync;
    logic pin_level;
    logic pin_out;
    logic left_muted;
    logic right_muted;
  } bank_state_t;

endpackage

//--- rtl/amp_misc_control_bank.sv
/*
  misc control register bank of a digital-input class-d amplifier:
  silence timeouts and auto-mute state, loop bandwidth, attenuation,
  modulator and dither setup, coefficient write marker, multi-purpose pin,
  dsp bypass options and a read-only chip identifier.
  assumes the serial control port decodes each byte access into one-cycle
  write or read strobes with a byte address, and that sample, clock and
  fault indications come from logic on the same clock.
*/
module amp_misc_control_bank #(
  parameter logic [7:0] chip_id_value = 8'h5a, // arbitrary value
  parameter int unsigned timeout_scale_den = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register access from the serial control port
  input wire amp_misc_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // auto-mute control and sample stream
  input wire logic left_mute_enable,
  input wire logic right_mute_enable,
  input wire logic joint_mute_enable,
  input wire logic sample_strobe,
  input wire logic left_sample_zero,
  input wire logic right_sample_zero,
  output logic left_muted,
  output logic right_muted,
  // system indications
  input wire logic clock_error,
  input wire logic clock_missing,
  input wire logic device_fault,
  // multi-purpose pin
  input wire logic multi_pin_i,
  output logic multi_pin_o,
  output logic multi_pin_oe,
  output logic multi_pin_level,
  // analog and modulator controls
  output logic [1:0] loop_bandwidth_code,
  output logic [4:0] output_attenuation_code,
  output logic dac_rate_slow,
  output logic dither_main_en,
  output logic dither_second_en,
  output logic [4:0] dither_exponent,
  output logic [1:0] mismatch_shaping_select,
  // coefficient and dsp controls
  output logic coef_set_start,
  output logic first_coef_marker,
  output logic right_own_coef,
  output logic fir_bypass,
  output logic drc_bypass_lr,
  output logic eq_bypass_lr
);
  import amp_misc_pkg::*;

  bank_state_t state;
  bank_state_t next_state;
  logic left_silent;
  logic right_silent;
  logic both_silent;
  logic clock_invalid;
  logic [2:0] dither_code;

  // true for an offset that holds a register
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      OFS_SILENCE_TIMEOUT, OFS_LOOP_BW, OFS_ATTENUATION, OFS_COEF_MARKER,
      OFS_MODULATOR, OFS_PIN_DIRECTION, OFS_PIN_FUNCTION, OFS_DSP_BYPASS,
      OFS_CHIP_ID: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // read value of an offset, zero when unmapped
  function automatic logic [7:0] read_value(input bank_state_t s, input logic [7:0] addr);
    case (addr)
      OFS_SILENCE_TIMEOUT: return s.silence_timeout;
      OFS_LOOP_BW: return s.loop_bandwidth_ctrl;
      OFS_ATTENUATION: return s.output_attenuation;
      OFS_COEF_MARKER: return s.coef_write_marker;
      OFS_MODULATOR: return s.modulator_config;
      OFS_PIN_DIRECTION: return s.multi_pin_direction;
      OFS_PIN_FUNCTION: return s.multi_pin_function;
      OFS_DSP_BYPASS: return s.dsp_bypass_options;
      OFS_CHIP_ID: return chip_id_value;
      default: return 8'h00;
    endcase
  endfunction

  // per-channel zero-run timers
  silence_timer #(
    .scale_den(timeout_scale_den)
  ) u_left_timer (
    .clk(clk),
    .resetn(resetn),
    .sample_strobe(sample_strobe),
    .sample_zero(left_sample_zero),
    .enable(left_mute_enable),
    .timeout_code(state.silence_timeout[LEFT_TIMEOUT_LSB +: 3]),
    .silent(left_silent)
  );

  silence_timer #(
    .scale_den(timeout_scale_den)
  ) u_right_timer (
    .clk(clk),
    .resetn(resetn),
    .sample_strobe(sample_strobe),
    .sample_zero(right_sample_zero),
    .enable(right_mute_enable),
    .timeout_code(state.silence_timeout[RIGHT_TIMEOUT_LSB +: 3]),
    .silent(right_silent)
  );

  assign both_silent = left_silent && right_silent;
  assign clock_invalid = clock_error || clock_missing;

  always_comb begin
    next_state = state;
    next_state.rvalid = 1'b0;
    next_state.coef_start = 1'b0;

    // writes store every bit, reserved ones included
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        OFS_SILENCE_TIMEOUT: next_state.silence_timeout = reg_req.wdata;
        OFS_LOOP_BW: next_state.loop_bandwidth_ctrl = reg_req.wdata;
        OFS_ATTENUATION: next_state.output_attenuation = reg_req.wdata;
        OFS_COEF_MARKER: begin
          next_state.coef_write_marker = reg_req.wdata;
          next_state.coef_start = reg_req.wdata[COEF_FIRST_BIT];
        end
        OFS_MODULATOR: next_state.modulator_config = reg_req.wdata;
        OFS_PIN_DIRECTION: next_state.multi_pin_direction = reg_req.wdata;
        OFS_PIN_FUNCTION: next_state.multi_pin_function = reg_req.wdata;
        OFS_DSP_BYPASS: next_state.dsp_bypass_options = reg_req.wdata;
        default: begin
          // chip identifier and unmapped offsets ignore writes
          next_state.silence_timeout = state.silence_timeout;
        end
      endcase
    end

    if (reg_req.rd) begin
      next_state.rdata = read_value(state, reg_req.addr);
      next_state.rvalid = 1'b1;
    end

    // auto-mute state, joint or per channel
    if (joint_mute_enable) begin
      next_state.left_muted = both_silent;
      next_state.right_muted = both_silent;
    end else begin
      next_state.left_muted = left_silent;
      next_state.right_muted = right_silent;
    end

    // multi-purpose pin input filter
    next_state.pin_sync = {state.pin_sync[1:0], multi_pin_i};
    if (state.pin_sync[1] == state.pin_sync[2]) begin
      next_state.pin_level = state.pin_sync[2];
    end

    // multi-purpose pin output function
    case (state.multi_pin_function[PIN_FUNC_LSB +: 5])
      PIN_OFF: next_state.pin_out = 1'b0;
      PIN_BOTH_MUTE: next_state.pin_out = state.left_muted && state.right_muted;
      PIN_LEFT_MUTE: next_state.pin_out = state.left_muted;
      PIN_RIGHT_MUTE: next_state.pin_out = state.right_muted;
      PIN_CLK_INVALID: next_state.pin_out = clock_invalid;
      PIN_FAULT: next_state.pin_out = !device_fault;
      default: next_state.pin_out = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= '0;
      state.silence_timeout <= RST_SILENCE_TIMEOUT;
      state.loop_bandwidth_ctrl <= RST_LOOP_BW;
      state.output_attenuation <= RST_ATTENUATION;
      state.coef_write_marker <= RST_COEF_MARKER;
      state.modulator_config <= RST_MODULATOR;
      state.multi_pin_direction <= RST_PIN_DIRECTION;
      state.multi_pin_function <= RST_PIN_FUNCTION;
      state.dsp_bypass_options <= RST_DSP_BYPASS;
    end else begin
      state <= next_state;
    end
  end

  // register port
  assign reg_rdata = state.rdata;
  assign reg_rvalid = state.rvalid;

  // status and pin
  assign left_muted = state.left_muted;
  assign right_muted = state.right_muted;
  assign multi_pin_o = state.pin_out;
  assign multi_pin_oe = state.multi_pin_direction[PIN_OE_BIT];
  assign multi_pin_level = state.pin_level;

  // analog and modulator controls
  assign loop_bandwidth_code = state.loop_bandwidth_ctrl[LOOP_BW_LSB +: 2];
  assign output_attenuation_code = state.output_attenuation[ATTEN_LSB +: 5];
  assign dac_rate_slow = state.modulator_config[DAC_RATE_BIT];
  assign dither_main_en = state.modulator_config[DITHER_EN_LSB];
  assign dither_second_en = state.modulator_config[DITHER_EN_LSB + 1];
  assign dither_code = state.modulator_config[DITHER_LEVEL_LSB +: 3];
  assign dither_exponent = dither_code[2] ?
    DITHER_EXP_HIGH_BASE + {3'h0, dither_code[1:0]} :
    DITHER_EXP_LOW_BASE + {3'h0, dither_code[1:0]};
  assign mismatch_shaping_select = state.modulator_config[MISMATCH_LSB +: 2];

  // coefficient and dsp controls
  assign coef_set_start = state.coef_start;
  assign first_coef_marker = state.coef_write_marker[COEF_FIRST_BIT];
  assign right_own_coef = state.dsp_bypass_options[OWN_COEF_BIT];
  assign fir_bypass = state.dsp_bypass_options[FIR_BYPASS_BIT];
  assign drc_bypass_lr = state.dsp_bypass_options[DRC_BYPASS_BIT];
  assign eq_bypass_lr = state.dsp_bypass_options[EQ_BYPASS_BIT];

  // checks
  a_chip_id_read: assert property (@(posedge clk) disable iff (!resetn)
    (reg_req.rd && reg_req.addr == OFS_CHIP_ID) |=> (reg_rvalid && reg_rdata == chip_id_value))
    else $error("chip identifier read wrong");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
    (reg_req.rd && !is_mapped(reg_req.addr)) |=> (reg_rdata == 8'h00))
    else $error("unmapped read not zero");

  a_write_readback: assert property (@(posedge clk) disable iff (!resetn)
    (reg_req.wr && reg_req.addr == OFS_DSP_BYPASS && !reg_req.rd) ##1
    (reg_req.rd && reg_req.addr == OFS_DSP_BYPASS && !reg_req.wr) |=>
    (reg_rdata == $past(reg_req.wdata, 2)))
    else $error("bypass options readback mismatch");

  a_coef_pulse: assert property (@(posedge clk) disable iff (!resetn)
    (reg_req.wr && reg_req.addr == OFS_COEF_MARKER && reg_req.wdata[0]) |=>
    (coef_set_start ##1 !coef_set_start || $past(reg_req.wr, 1)))
    else $error("coefficient start pulse missing");

  a_dac_rate_write: assert property (@(posedge clk) disable iff (!resetn)
    (reg_req.wr && reg_req.addr == OFS_MODULATOR) |=> (dac_rate_slow == $past(reg_req.wdata[7])))
    else $error("dac rate bit not updated");

  a_pin_dir_write: assert property (@(posedge clk) disable iff (!resetn)
    (reg_req.wr && reg_req.addr == OFS_PIN_DIRECTION) |=> (multi_pin_oe == $past(reg_req.wdata[0])))
    else $error("pin direction not updated");

  a_pin_off_low: assert property (@(posedge clk) disable iff (!resetn)
    (state.multi_pin_function[4:0] == 5'h00) |=> !multi_pin_o)
    else $error("pin not low when off");

  a_pin_both_mute: assert property (@(posedge clk) disable iff (!resetn)
    (state.multi_pin_function[4:0] == 5'h03) |=> (multi_pin_o == $past(left_muted && right_muted)))
    else $error("pin does not follow joint mute");

  a_pin_fault: assert property (@(posedge clk) disable iff (!resetn)
    (state.multi_pin_function[4:0] == 5'h0b) |=> (multi_pin_o == !$past(device_fault)))
    else $error("pin does not show fault");

  a_joint_mute: assert property (@(posedge clk) disable iff (!resetn)
    (joint_mute_enable && $past(joint_mute_enable)) |-> (left_muted == right_muted))
    else $error("joint mute channels differ");

  a_mute_follow: assert property (@(posedge clk) disable iff (!resetn)
    (!joint_mute_enable && !left_silent) |=> !left_muted)
    else $error("left mute without silence");

endmodule

//--- rtl/silence_timer.sv
/*
  counts an unbroken run of zero samples on one channel and flags silence
  once the run reaches the selected timeout length.
  assumes sample strobes and zero flags come from logic on the same clock.
*/
module silence_timer #(
  parameter int unsigned scale_den = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // channel sample stream
  input wire logic sample_strobe,
  input wire logic sample_zero,
  input wire logic enable,
  input wire logic [2:0] timeout_code,
  // result
  output logic silent
);
  import amp_misc_pkg::*;

  timer_state_t state;
  timer_state_t next_state;
  logic [COUNT_W-1:0] limit;
  logic [COUNT_W-1:0] raw;

  always_comb begin
    raw = timeout_samples(timeout_code) / COUNT_W'(scale_den);
    limit = (raw == '0) ? COUNT_W'(1) : raw;
    next_state = state;
    if (!enable || (sample_strobe && !sample_zero)) begin
      next_state.count = '0;
      next_state.silent = 1'b0;
    end else if (sample_strobe) begin
      // counting samples keeps the timeout inversely proportional to the sample rate
      if (state.count < limit) begin
        next_state.count = state.count + COUNT_W'(1);
      end
      next_state.silent = (next_state.count >= limit);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign silent = state.silent;

  a_zero_break: assert property (@(posedge clk) disable iff (!resetn)
    (sample_strobe && !sample_zero) |=> !silent)
    else $error("nonzero sample did not clear silence");

  a_silent_count: assert property (@(posedge clk) disable iff (!resetn)
    silent |-> (state.count >= limit || $past(state.count) >= limit))
    else $error("silence flagged before timeout length");

endmodule

//--- verification/testbench.sv
/*
  self-checking testbench for the amplifier misc control bank.
  assumes the bank answers reads with registered data valid just after the taking edge and that
  silence lengths are divided by timeout_scale_den.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import amp_misc_pkg::*;

  localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value

  logic clk, resetn, lme, rme, jme, strobe, lz, rz, cerr, cmiss, dfault, pin_i;
  reg_req_t reg_req;
  logic [7:0] rdata;
  logic rvalid, lmuted, rmuted, pin_o, pin_oe, pin_lvl, dslow, dmain, dsec;
  logic coef_start, first_coef, own_coef, fir_byp, drc_byp, eq_byp;
  logic [1:0] bw, dem;
  logic [4:0] atten, dexp;
  int fails = 0;
  int check_count = 0;

  amp_misc_control_bank #(.chip_id_value(ID_VAL), .timeout_scale_den(1000)) DUT (
    .clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .left_mute_enable(lme), .right_mute_enable(rme),
    .joint_mute_enable(jme), .sample_strobe(strobe), .left_sample_zero(lz),
    .right_sample_zero(rz), .left_muted(lmuted), .right_muted(rmuted),
    .clock_error(cerr), .clock_missing(cmiss), .device_fault(dfault),
    .multi_pin_i(pin_i), .multi_pin_o(pin_o), .multi_pin_oe(pin_oe),
    .multi_pin_level(pin_lvl), .loop_bandwidth_code(bw),
    .output_attenuation_code(atten), .dac_rate_slow(dslow), .dither_main_en(dmain),
    .dither_second_en(dsec), .dither_exponent(dexp), .mismatch_shaping_select(dem),
    .coef_set_start(coef_start), .first_coef_marker(first_coef),
    .right_own_coef(own_coef), .fir_bypass(fir_byp), .drc_bypass_lr(drc_byp),
    .eq_bypass_lr(eq_byp));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict();
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) reg_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) reg_req <= '0;
    #1;
    chk("rvalid", 8'h01, {7'h0, rvalid});
    chk("rdata", exp, rdata);
  endtask

  task automatic samples(input int n, input logic l, input logic r);
    repeat (n) begin
      @(posedge clk) strobe <= 1'b1;
      lz <= l;
      rz <= r;
      @(posedge clk) strobe <= 1'b0;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic pin_chk(input logic [7:0] f, input logic exp);
    wr(OFS_PIN_FUNCTION, f);
    repeat (3) @(posedge clk);
    #1;
    chk("multi_pin_o", {7'h0, exp}, {7'h0, pin_o});
  endtask

  task automatic reset_values();
    logic [7:0] ofs [8] = '{OFS_SILENCE_TIMEOUT, OFS_LOOP_BW, OFS_ATTENUATION,
      OFS_COEF_MARKER, OFS_MODULATOR, OFS_PIN_DIRECTION, OFS_PIN_FUNCTION, OFS_DSP_BYPASS};
    logic [7:0] rv [8] = '{RST_SILENCE_TIMEOUT, RST_LOOP_BW, RST_ATTENUATION,
      RST_COEF_MARKER, RST_MODULATOR, RST_PIN_DIRECTION, RST_PIN_FUNCTION, RST_DSP_BYPASS};
    #1;
    chk("reset outputs", 8'he9, {dslow, dmain, dsec, dexp});
    chk("reset pin_oe", 8'h00, {7'h0, pin_oe});
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i], rv[i]);
    end
  endtask

  task automatic id_and_unmapped();
    wr(OFS_CHIP_ID, 8'hff);
    rd(OFS_CHIP_ID, ID_VAL);
    wr(8'h52, 8'ha5);
    rd(8'h52, 8'h00);
  endtask

  task automatic back_to_back();
    @(posedge clk) reg_req <= '{1'b1, 1'b0, OFS_DSP_BYPASS, 8'h5c};
    @(posedge clk) reg_req <= '{1'b0, 1'b1, OFS_DSP_BYPASS, 8'h00};
    @(posedge clk) reg_req <= '0;
    #1;
    chk("back to back rvalid", 8'h01, {7'h0, rvalid});
    chk("back to back rdata", 8'h5c, rdata);
    @(posedge clk) reg_req <= '{1'b1, 1'b1, OFS_DSP_BYPASS, 8'h33};
    @(posedge clk) reg_req <= '0;
    #1;
    chk("same cycle read old", 8'h5c, rdata);
    rd(OFS_DSP_BYPASS, 8'h33);
  endtask

  task automatic field_decodes();
    logic [2:0] c;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {1'b1, i[1:0], 5'h15};
      wr(OFS_LOOP_BW, d);
      rd(OFS_LOOP_BW, d);
      chk("loop_bandwidth_code", {6'h0, i[1:0]}, {6'h0, bw});
    end
    for (int i = 0; i < 3; i++) begin
      d = {3'h5, i == 0 ? 5'h00 : i == 1 ? 5'h01 : 5'h1f};
      wr(OFS_ATTENUATION, d);
      rd(OFS_ATTENUATION, d);
      chk("output_attenuation_code", {3'h0, d[4:0]}, {3'h0, atten});
    end
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      d = {c[0], c[1:0], c, c[1:0]};
      wr(OFS_MODULATOR, d);
      rd(OFS_MODULATOR, d);
      chk("dac_rate_slow", {7'h0, c[0]}, {7'h0, dslow});
      chk("dither enables", {6'h0, c[1:0]}, {6'h0, dsec, dmain});
      chk("dither_exponent", c[2] ? 8'd7 + c[1:0] : 8'd13 + c[1:0], {3'h0, dexp});
      chk("mismatch_shaping_select", {6'h0, c[1:0]}, {6'h0, dem});
    end
    for (int i = 0; i < 4; i++) begin
      d = 8'ha0 | (8'h01 << i);
      wr(OFS_DSP_BYPASS, d);
      rd(OFS_DSP_BYPASS, d);
      chk("bypass outputs", {4'h0, d[3:0]}, {4'h0, own_coef, fir_byp, drc_byp, eq_byp});
    end
  endtask

  task automatic coef_marker();
    int n;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      wr(OFS_COEF_MARKER, {7'h0, i[0]});
      for (int k = 0; k < 4; k++) begin
        #1;
        n += int'(coef_start === 1'b1);
        @(posedge clk);
      end
      chk("coef_set_start pulses", {7'h0, i[0]}, n[7:0]);
      chk("first_coef_marker", {7'h0, i[0]}, {7'h0, first_coef});
    end
  endtask

  task automatic mute_and_pin();
    wr(OFS_PIN_DIRECTION, 8'h01);
    #1;
    chk("pin_oe", 8'h01, {7'h0, pin_oe});
    wr(OFS_SILENCE_TIMEOUT, 8'h10);
    samples(4, 1'b1, 1'b1);
    chk("mutes after 4", 8'h01, {6'h0, lmuted, rmuted});
    samples(1, 1'b1, 1'b1);
    chk("mutes after 5", 8'h03, {6'h0, lmuted, rmuted});
    pin_chk(8'h03, 1'b1);
    samples(1, 1'b0, 1'b1);
    chk("left cleared", 8'h01, {6'h0, lmuted, rmuted});
    pin_chk(8'h03, 1'b0);
    pin_chk(8'h04, 1'b0);
    pin_chk(8'h05, 1'b1);
    pin_chk(8'h00, 1'b0);
    pin_chk(8'h06, 1'b0);
    @(posedge clk) cerr <= 1'b1;
    pin_chk(8'h06, 1'b1);
    @(posedge clk) cerr <= 1'b0;
    cmiss <= 1'b1;
    pin_chk(8'h06, 1'b1);
    @(posedge clk) cmiss <= 1'b0;
    pin_chk(8'h0b, 1'b1);
    pin_chk(8'h09, 1'b0);
    @(posedge clk) dfault <= 1'b1;
    pin_chk(8'h0b, 1'b0);
    @(posedge clk) jme <= 1'b1;
    samples(1, 1'b0, 1'b1);
    chk("joint one silent", 8'h00, {6'h0, lmuted, rmuted});
    samples(5, 1'b1, 1'b1);
    chk("joint both silent", 8'h03, {6'h0, lmuted, rmuted});
    wr(OFS_PIN_DIRECTION, 8'h00);
    pin_i <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk("pin_oe off", 8'h00, {7'h0, pin_oe});
    chk("multi_pin_level", 8'h01, {7'h0, pin_lvl});
  endtask

  initial begin
    resetn = 1'b0;
    reg_req = '0;
    {lme, rme, jme, strobe, lz, rz, cerr, cmiss, dfault, pin_i} = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    lme <= 1'b1;
    rme <= 1'b1;
    @(posedge clk);
    reset_values();
    id_and_unmapped();
    back_to_back();
    field_decodes();
    coef_marker();
    mute_and_pin();
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule
